//--- design/address_adder.sv
// Combinational effective address and branch target former.
// Assumes operand, pointer and index are registered upstream.
`timescale 1ns/1ps
module address_adder (
    input  wire addr_gen_pkg::mode_e mode,
    input  wire logic [15:0]         oper,
    input  wire logic [15:0]         ptr,
    input  wire logic [7:0]          index,
    input  wire logic [15:0]         pc_end,
    output logic [15:0]              ea,
    output logic [15:0]              target
);
    import addr_gen_pkg::*;

    function automatic logic [15:0] widen(input logic [7:0] b);
        widen = {8'h00, b};
    endfunction : widen

    logic [7:0] offset;

    always_comb begin
        ea     = '0;
        offset = '0;
        case (mode)
            M_SHORT_DIR, M_BIT_DIR:  ea = widen(oper[7:0]);
            M_BIT_DIR_REL:           ea = widen(oper[15:8]);
            M_LONG_DIR:              ea = oper;
            M_NOOFS_IDX:             ea = widen(index);
            // Nine-bit sum, no page wrap
            M_SHORT_IDX:             ea = widen(oper[7:0]) + widen(index);
            M_LONG_IDX:              ea = oper + widen(index);
            M_SHORT_IND, M_BIT_IND,
            M_BIT_IND_REL:           ea = widen(ptr[7:0]);
            M_LONG_IND:              ea = ptr;
            M_SHORT_IND_IDX:         ea = widen(ptr[7:0]) + widen(index);
            M_LONG_IND_IDX:          ea = ptr + widen(index);
            default:                 ea = '0;
        endcase
        case (mode)
            M_REL_DIR:                     offset = oper[7:0];
            M_REL_IND:                     offset = ptr[7:0];
            M_BIT_DIR_REL, M_BIT_IND_REL:  offset = oper[7:0];
            default:                       offset = '0;
        endcase
        target = pc_end + {{8{offset[7]}}, offset};
    end

endmodule : address_adder

//--- design/mode_classifier.sv
// Combinational opcode and prefix classifier.
// Assumes opcode and prefix are held stable in registers by the sequencer.
`timescale 1ns/1ps
module mode_classifier (
    input  wire logic [7:0]            opcode,
    input  wire addr_gen_pkg::prefix_e prefix,
    output addr_gen_pkg::decode_s      dec
);
    import addr_gen_pkg::*;

    logic [3:0] row;
    logic       ind;
    logic       ind_ok;
    logic       y_ok;

    always_comb begin
        row       = opcode[7:4];
        ind       = (prefix == PFX_IND_SEL) || (prefix == PFX_YIND_SEL);
        dec       = '0;
        dec.mode  = M_INHERENT;
        dec.op    = opcode[3:0];
        dec.use_y = (prefix == PFX_Y_SEL) || (prefix == PFX_YIND_SEL);
        ind_ok    = 1'b1;
        y_ok      = 1'b0;
        case (row)
            ROW_BIT_REL: begin
                dec.mode   = ind ? M_BIT_IND_REL : M_BIT_DIR_REL;
                dec.opnd_n = 2'd2;
                dec.ptr_n  = ind ? 2'd1 : 2'd0;
            end
            ROW_BIT: begin
                dec.mode   = ind ? M_BIT_IND : M_BIT_DIR;
                dec.opnd_n = 2'd1;
                dec.ptr_n  = ind ? 2'd1 : 2'd0;
            end
            ROW_REL: begin
                dec.mode   = ind ? M_REL_IND : M_REL_DIR;
                dec.opnd_n = 2'd1;
                dec.ptr_n  = ind ? 2'd1 : 2'd0;
            end
            ROW_RMW_DIR, ROW_SDIR: begin
                // Memory-to-memory rows exist in short form only
                dec.mode   = ind ? M_SHORT_IND : M_SHORT_DIR;
                dec.opnd_n = 2'd1;
                dec.ptr_n  = ind ? 2'd1 : 2'd0;
            end
            ROW_RMW_SIDX, ROW_SIDX: begin
                dec.mode   = ind ? M_SHORT_IND_IDX : M_SHORT_IDX;
                dec.opnd_n = 2'd1;
                dec.ptr_n  = ind ? 2'd1 : 2'd0;
                y_ok       = 1'b1;
            end
            ROW_RMW_NOFS, ROW_NOFS: begin
                dec.mode = M_NOOFS_IDX;
                ind_ok   = 1'b0;
                y_ok     = 1'b1;
            end
            ROW_IMM: begin
                dec.mode    = M_IMMEDIATE;
                dec.opnd_n  = 2'd1;
                ind_ok      = 1'b0;
                dec.illegal = (opcode[3:0] == OP_STORE) || (opcode[3:0] == OP_JUMP)
                              || (opcode[3:0] == OP_CALL);
            end
            ROW_LDIR: begin
                dec.mode   = ind ? M_LONG_IND : M_LONG_DIR;
                dec.opnd_n = ind ? 2'd1 : 2'd2;
                dec.ptr_n  = ind ? 2'd2 : 2'd0;
            end
            ROW_LIDX: begin
                dec.mode   = ind ? M_LONG_IND_IDX : M_LONG_IDX;
                dec.opnd_n = ind ? 2'd1 : 2'd2;
                dec.ptr_n  = ind ? 2'd2 : 2'd0;
                y_ok       = 1'b1;
            end
            ROW_INH_X: begin
                ind_ok = 1'b0;
                y_ok   = 1'b1;
            end
            ROW_CTRL: begin
                ind_ok   = 1'b0;
                dec.ctrl = 1'b1;
            end
            default: begin
                ind_ok = 1'b0;
            end
        endcase
        // Prefixes only legal where a Y or indirect twin exists
        case (prefix)
            PFX_Y_SEL:    dec.illegal = dec.illegal | ~y_ok;
            PFX_IND_SEL:  dec.illegal = dec.illegal | ~ind_ok;
            PFX_YIND_SEL: dec.illegal = dec.illegal | ~(ind_ok & y_ok);
            default:      dec.illegal = dec.illegal;
        endcase
    end

endmodule : mode_classifier

//--- design/operand_address_generator.sv
// Operand address generator: fetches prefix, opcode, operand and pointer bytes.
// Assumes a same-clock memory port that answers a held request with an ack.
`timescale 1ns/1ps
module operand_address_generator (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   start,
    input  wire logic [15:0]            pc_start,
    input  wire logic [7:0]             x_index,
    input  wire logic [7:0]             y_index,
    input  wire logic                   irq_pending,
    input  wire logic                   mem_ack,
    input  wire logic [7:0]             mem_rdata,
    output logic                        mem_req,
    output logic [15:0]                 mem_addr,
    output logic                        done,
    output addr_gen_pkg::result_s       result,
    output logic [3:0]                  inherent_op,
    output logic [1:0]                  interrupt_mask,
    output logic                        osc_stop,
    output logic                        wait_for_interrupt
);
    import addr_gen_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_DECODE, ST_OPERAND, ST_POINTER, ST_FINISH
    } state_e;

    state_e      state_r, state_nxt;
    prefix_e     pfx_r, pfx_nxt;
    logic [7:0]  opcode_r, opcode_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] oper_r, oper_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic [1:0]  cnt_r, cnt_nxt;
    logic [2:0]  len_r, len_nxt;
    logic        req_r, req_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic        done_r, done_nxt;
    result_s     res_r, res_nxt;
    logic [3:0]  op_r, op_nxt;
    logic [1:0]  imask_r, imask_nxt;
    logic        halt_r, halt_nxt;
    logic        wait_r, wait_nxt;

    decode_s     dec;
    logic [7:0]  index;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0]  ptr_loc;

    mode_classifier u_classifier (
        .opcode (opcode_r),
        .prefix (pfx_r),
        .dec    (dec)
    );

    assign index = dec.use_y ? y_index : x_index;

    address_adder u_adder (
        .mode   (dec.mode),
        .oper   (oper_r),
        .ptr    (ptr_r),
        .index  (index),
        .pc_end (pc_r),
        .ea     (ea),
        .target (target)
    );

    always_comb begin
        state_nxt  = state_r;
        pfx_nxt    = pfx_r;
        opcode_nxt = opcode_r;
        pc_nxt     = pc_r;
        oper_nxt   = oper_r;
        ptr_nxt    = ptr_r;
        cnt_nxt    = cnt_r;
        len_nxt    = len_r;
        req_nxt    = req_r;
        addr_nxt   = addr_r;
        done_nxt   = 1'b0;
        res_nxt    = res_r;
        op_nxt     = op_r;
        imask_nxt  = imask_r;
        halt_nxt   = halt_r;
        wait_nxt   = wait_r;
        ptr_loc    = '0;
        // Any pending interrupt ends both low-power states
        if (irq_pending) begin
            halt_nxt = 1'b0;
            wait_nxt = 1'b0;
        end
        case (state_r)
            ST_IDLE: begin
                // No fetch while the core sleeps
                if (start && !halt_r && !wait_r) begin
                    pc_nxt    = pc_start;
                    addr_nxt  = pc_start;
                    req_nxt   = 1'b1;
                    pfx_nxt   = PFX_NONE;
                    len_nxt   = LEN_RESET;
                    state_nxt = ST_OPCODE;
                end
            end
            ST_OPCODE: begin
                if (mem_ack) begin
                    pc_nxt   = pc_r + 16'h0001;
                    addr_nxt = pc_r + 16'h0001;
                    len_nxt  = len_r + 3'd1;
                    // Only one prefix is honoured; a second is taken as an opcode
                    if (pfx_r == PFX_NONE && mem_rdata == Y_REGISTER_PREFIX) begin
                        pfx_nxt = PFX_Y_SEL;
                    end else if (pfx_r == PFX_NONE && mem_rdata == Y_INDIRECT_PREFIX) begin
                        pfx_nxt = PFX_YIND_SEL;
                    end else if (pfx_r == PFX_NONE && mem_rdata == INDIRECT_PREFIX) begin
                        pfx_nxt = PFX_IND_SEL;
                    end else begin
                        opcode_nxt = mem_rdata;
                        req_nxt    = 1'b0;
                        state_nxt  = ST_DECODE;
                    end
                end
            end
            ST_DECODE: begin
                oper_nxt = '0;
                ptr_nxt  = '0;
                cnt_nxt  = dec.opnd_n;
                if (dec.opnd_n != 2'd0) begin
                    req_nxt   = 1'b1;
                    addr_nxt  = pc_r;
                    state_nxt = ST_OPERAND;
                end else begin
                    state_nxt = ST_FINISH;
                end
            end
            ST_OPERAND: begin
                if (mem_ack) begin
                    oper_nxt = {oper_r[7:0], mem_rdata};
                    pc_nxt   = pc_r + 16'h0001;
                    len_nxt  = len_r + 3'd1;
                    cnt_nxt  = cnt_r - 2'd1;
                    addr_nxt = pc_r + 16'h0001;
                    if (cnt_r == 2'd1) begin
                        // Pointer location is the first byte after the opcode
                        ptr_loc = (dec.opnd_n == 2'd2) ? oper_r[7:0] : mem_rdata;
                        if (dec.ptr_n != 2'd0) begin
                            cnt_nxt   = dec.ptr_n;
                            addr_nxt  = {8'h00, ptr_loc};
                            state_nxt = ST_POINTER;
                        end else begin
                            req_nxt   = 1'b0;
                            state_nxt = ST_FINISH;
                        end
                    end
                end
            end
            ST_POINTER: begin
                if (mem_ack) begin
                    ptr_nxt  = {ptr_r[7:0], mem_rdata};
                    cnt_nxt  = cnt_r - 2'd1;
                    // Word pointer stays inside page zero
                    addr_nxt = {8'h00, addr_r[7:0] + 8'h01};
                    if (cnt_r == 2'd1) begin
                        req_nxt   = 1'b0;
                        state_nxt = ST_FINISH;
                    end
                end
            end
            ST_FINISH: begin
                done_nxt        = 1'b1;
                res_nxt.mode    = dec.mode;
                res_nxt.ea      = ea;
                res_nxt.target  = target;
                res_nxt.length  = len_r;
                res_nxt.illegal = dec.illegal;
                op_nxt          = dec.op;
                if (dec.ctrl && !dec.illegal) begin
                    case (dec.op)
                        OP_RAISE_MASK:         imask_nxt = IMASK_RAISED;
                        OP_LOWER_MASK:         imask_nxt = IMASK_LOWERED;
                        OP_HALT:               halt_nxt  = 1'b1;
                        OP_WAIT_FOR_INTERRUPT: wait_nxt  = 1'b1;
                        default:               imask_nxt = imask_r;
                    endcase
                end
                state_nxt = ST_IDLE;
            end
            default: begin
                req_nxt   = 1'b0;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r  <= ST_IDLE;
            pfx_r    <= PFX_NONE;
            opcode_r <= '0;
            pc_r     <= '0;
            oper_r   <= '0;
            ptr_r    <= '0;
            cnt_r    <= '0;
            len_r    <= LEN_RESET;
            req_r    <= 1'b0;
            addr_r   <= '0;
            done_r   <= 1'b0;
            res_r    <= '0;
            op_r     <= '0;
            imask_r  <= IMASK_RESET;
            halt_r   <= 1'b0;
            wait_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            pfx_r    <= pfx_nxt;
            opcode_r <= opcode_nxt;
            pc_r     <= pc_nxt;
            oper_r   <= oper_nxt;
            ptr_r    <= ptr_nxt;
            cnt_r    <= cnt_nxt;
            len_r    <= len_nxt;
            req_r    <= req_nxt;
            addr_r   <= addr_nxt;
            done_r   <= done_nxt;
            res_r    <= res_nxt;
            op_r     <= op_nxt;
            imask_r  <= imask_nxt;
            halt_r   <= halt_nxt;
            wait_r   <= wait_nxt;
        end
    end

    assign mem_req            = req_r;
    assign mem_addr           = addr_r;
    assign done               = done_r;
    assign result             = res_r;
    assign inherent_op        = op_r;
    assign interrupt_mask     = imask_r;
    assign osc_stop           = halt_r;
    assign wait_for_interrupt = wait_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_ctrl_done;
        done_r && res_r.mode == M_INHERENT && !res_r.illegal && opcode_r[7:4] == ROW_CTRL;
    endsequence

    sequence s_raise_done;
        s_ctrl_done ##0 op_r == OP_RAISE_MASK;
    endsequence

    sequence s_wait_done;
        s_ctrl_done ##0 op_r == OP_WAIT_FOR_INTERRUPT;
    endsequence

    a_inherent_len: assert property (done_r && res_r.mode == M_INHERENT && pfx_r == PFX_NONE
        |-> res_r.length == 3'd1)
        else $error("inherent instruction not one byte");

    a_immediate_len: assert property (done_r && res_r.mode == M_IMMEDIATE
        |-> res_r.length == 3'd2 + {2'b00, pfx_r != PFX_NONE})
        else $error("immediate instruction not two bytes");

    a_short_page: assert property (done_r && (res_r.mode == M_SHORT_DIR || res_r.mode == M_SHORT_IND
        || res_r.mode == M_BIT_DIR) |-> res_r.ea <= PAGE_ZERO_TOP)
        else $error("short form left page zero");

    a_noofs_index: assert property (done_r && res_r.mode == M_NOOFS_IDX
        |-> res_r.ea == {8'h00, $past(index)} && res_r.length == 3'd1 + {2'b00, pfx_r != PFX_NONE})
        else $error("no-offset indexed address or length wrong");

    a_short_sum: assert property (done_r && (res_r.mode == M_SHORT_IDX || res_r.mode == M_SHORT_IND_IDX)
        |-> res_r.ea <= SHORT_IDX_TOP)
        else $error("short indexed sum out of range");

    a_long_dir_len: assert property (done_r && res_r.mode == M_LONG_DIR
        |-> res_r.length == 3'd3 && res_r.ea == $past(oper_r))
        else $error("long direct length or address wrong");

    a_pointer_page: assert property (state_r == ST_POINTER && req_r
        |-> addr_r[15:8] == 8'h00)
        else $error("pointer read outside page zero");

    a_rmw_short: assert property (done_r && (opcode_r[7:4] == ROW_RMW_DIR || opcode_r[7:4] == ROW_RMW_SIDX)
        |-> res_r.mode != M_LONG_DIR && res_r.mode != M_LONG_IDX && res_r.mode != M_LONG_IND)
        else $error("memory-to-memory op decoded long");

    a_mask_raise: assert property (s_raise_done |-> interrupt_mask == IMASK_RAISED)
        else $error("mask not raised to level 3");

    a_wait_entry: assert property (s_wait_done |-> wait_r ##1 (wait_r || $past(irq_pending)))
        else $error("wait state not entered");

    a_halt_hold: assert property (halt_r && !irq_pending |=> halt_r && state_r == ST_IDLE)
        else $error("halt left without interrupt");

endmodule : operand_address_generator

//--- dv/mem_partner.sv
// Byte-wide program/data memory answering the generator's read port.
// Assumes the bench loads mem by hierarchical reference before each start.
`timescale 1ns/1ps
module mem_partner (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata
);
    logic [7:0] mem [0:65535];
    logic       waited_r;
    logic [7:0] last_r;
    // Slow mode makes every read wait one cycle so a held request is seen
    always_ff @(posedge clk) begin
        waited_r <= !reset && mem_req && !mem_ack;
        if (reset) begin
            last_r <= 8'h00;
        end else if (mem_ack) begin
            last_r <= mem[mem_addr];
        end
    end
    assign mem_ack = mem_req && (!slow || waited_r);
    // Released bus shows the inverse of the last byte, never a stale copy
    assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_r;
endmodule : mem_partner

//--- dv/operand_address_generator_tb_top.sv
// Self-checking bench for the operand address generator.
// Assumes mem_partner on the memory port and a 125 MHz clock.
`timescale 1ns/1ps
module operand_address_generator_tb_top;
    import addr_gen_pkg::*;
    logic clk = 0, reset = 1, start = 0, irq_pending = 0, slow = 0;
    logic [15:0] pc_start = 16'h0000, mem_addr;
    logic [7:0]  x_index = 8'h00, y_index = 8'h00, mem_rdata;
    logic        mem_ack, mem_req, done, osc_stop, wait_for_interrupt;
    logic [3:0]  inherent_op;
    logic [1:0]  interrupt_mask;
    result_s     result;
    int          n_fail = 0, samples_checked = 0;
    always #4 clk = ~clk;
    operand_address_generator i_operand_address_generator (.clk(clk), .reset(reset), .start(start),
        .pc_start(pc_start), .x_index(x_index), .y_index(y_index), .irq_pending(irq_pending),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .done(done),
        .result(result), .inherent_op(inherent_op), .interrupt_mask(interrupt_mask),
        .osc_stop(osc_stop), .wait_for_interrupt(wait_for_interrupt));
    mem_partner i_mem_partner (.clk(clk), .reset(reset), .slow(slow), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task run(input logic [15:0] pc, input logic [31:0] code, input int n);
        for (int i = 0; i < n; i++) i_mem_partner.mem[pc + 16'(i)] = code[31 - 8 * i -: 8];
        @(posedge clk);
        start <= 1'b1;
        pc_start <= pc;
        @(posedge clk);
        start <= 1'b0;
        for (int k = 0; k < 100; k++) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) break;
        end
        chk("done", 16'h1, 16'(done));
    endtask : run
    task ea_is(input mode_e m, input logic [15:0] ea, input logic [2:0] len);
        chk("mode", 16'(m), 16'(result.mode));
        chk("ea", ea, result.ea);
        chk("length", 16'(len), 16'(result.length));
    endtask : ea_is
    task t_direct;
        run(16'h0200, 32'hB655_0000, 2);
        ea_is(M_SHORT_DIR, 16'h0055, 3'h2);
        run(16'h0210, 32'hC612_3400, 3);
        ea_is(M_LONG_DIR, 16'h1234, 3'h3);
    endtask : t_direct
    task t_indexed;
        @(posedge clk);
        x_index <= 8'hFF;
        y_index <= 8'h80;
        run(16'h0220, 32'hE6FF_0000, 2);
        ea_is(M_SHORT_IDX, 16'h01FE, 3'h2);
        run(16'h0230, 32'h90F6_0000, 2);
        ea_is(M_NOOFS_IDX, 16'h0080, 3'h2);
        run(16'h0240, 32'hD6FF_1000, 3);
        ea_is(M_LONG_IDX, 16'h000F, 3'h3);
    endtask : t_indexed
    task t_indirect;
        @(posedge clk);
        slow <= 1'b1;
        i_mem_partner.mem[16'h0010] = 8'h12;
        i_mem_partner.mem[16'h0011] = 8'h34;
        run(16'h0250, 32'h92B6_1000, 3);
        ea_is(M_SHORT_IND, 16'h0012, 3'h3);
        run(16'h0260, 32'h92C6_1000, 3);
        ea_is(M_LONG_IND, 16'h1234, 3'h3);
        i_mem_partner.mem[16'h0010] = 8'hFF;
        run(16'h0270, 32'h92E6_1000, 3);
        ea_is(M_SHORT_IND_IDX, 16'h01FE, 3'h3);
        run(16'h0280, 32'h91E6_1000, 3);
        ea_is(M_SHORT_IND_IDX, 16'h017F, 3'h3);
        slow <= 1'b0;
    endtask : t_indirect
    task t_imm_rel;
        run(16'h0290, 32'hA655_0000, 2);
        chk("mode", 16'(M_IMMEDIATE), 16'(result.mode));
        chk("length", 16'h2, 16'(result.length));
        chk("illegal", 16'h0, 16'(result.illegal));
        run(16'h02A0, 32'hA755_0000, 2);
        chk("illegal", 16'h1, 16'(result.illegal));
        run(16'h0300, 32'h20FE_0000, 2);
        chk("target", 16'h0300, result.target);
    endtask : t_imm_rel
    // Runs after t_indirect: page-zero pointer holds 0xFF, 0x34 and X holds 0xFF
    task t_bit_rel;
        run(16'h0320, 32'h0310_FC00, 3);
        ea_is(M_BIT_DIR_REL, 16'h0010, 3'h3);
        chk("target", 16'h031F, result.target);
        run(16'h0330, 32'h9222_1000, 3);
        chk("mode", 16'(M_REL_IND), 16'(result.mode));
        chk("length", 16'h3, 16'(result.length));
        chk("target", 16'h0332, result.target);
        run(16'h0340, 32'h92D6_1000, 3);
        ea_is(M_LONG_IND_IDX, 16'h0033, 3'h3);
    endtask : t_bit_rel
    task t_control;
        #1;
        chk("mask", 16'(IMASK_RESET), 16'(interrupt_mask));
        run(16'h0310, 32'h8700_0000, 1);
        chk("length", 16'h1, 16'(result.length));
        chk("inherent_op", 16'h7, 16'(inherent_op));
        chk("mask", 16'h0, 16'(interrupt_mask));
        run(16'h0311, 32'h8600_0000, 1);
        chk("mask", 16'h3, 16'(interrupt_mask));
        run(16'h0312, 32'h8300_0000, 1);
        chk("osc_stop", 16'h1, 16'(osc_stop));
        @(posedge clk);
        irq_pending <= 1'b1;
        @(posedge clk);
        irq_pending <= 1'b0;
        @(posedge clk);
        #1;
        chk("osc_stop", 16'h0, 16'(osc_stop));
        run(16'h0313, 32'h8200_0000, 1);
        chk("wait", 16'h1, 16'(wait_for_interrupt));
    endtask : t_control
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_control();
        @(posedge clk);
        irq_pending <= 1'b1;
        @(posedge clk);
        irq_pending <= 1'b0;
        t_direct();
        t_indexed();
        t_indirect();
        t_imm_rel();
        t_bit_rel();
        tally_and_finish();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #80000;
        n_fail++;
        tally_and_finish();
    end
endmodule : operand_address_generator_tb_top

//--- pkg/addr_gen_pkg.sv
// Shared types and constants for the operand address generator.
// Assumes one clock, a byte-wide memory port and big-endian operand words.
// Summary of operation
// - Seventeen operand addressing modes grouped into seven families.
// - Short forms address page zero, 0x0000 to 0x00FF.
// - Long forms reach the whole 64-Kbyte space.
// - Read-modify-write instructions decode short addressing forms only.
// - Inherent instructions are one byte, no operand bytes fetched.
// - Immediate is two bytes, only load, compare, logic and add/subtract.
// - Short direct uses one address byte after the opcode.
// - Long direct fetches a two-byte address word.
// - Indexed address is unsigned sum of X or Y and offset.
// - No-offset indexed fetches nothing, address is the index itself.
// - Short indexed fetches one offset byte, reaching up to 0x1FE.
// - Long indexed adds index to a two-byte offset word.
// - Indirect reads a pointer at the location given after the opcode.
// - Short indirect: byte location, byte pointer, operand in page zero.
// - Long indirect forms read a word pointer from a byte location.
// - Indirect-indexed address is pointer plus X or Y, unsigned.
// - Short indirect-indexed adds byte pointer to index, up to 0x1FE.
// - Raise mask instruction sets level 3, lower mask sets level 0.
// - Halt stops the oscillator; wait idles until an interrupt.
// - Relative target is PC plus signed 8-bit offset, direct or memory.
// - Prefix 0x90 selects Y, 0x92 indirect, 0x91 Y indirect-indexed.
package addr_gen_pkg;

    typedef enum logic [4:0] {
        M_INHERENT, M_IMMEDIATE, M_SHORT_DIR, M_LONG_DIR, M_NOOFS_IDX,
        M_SHORT_IDX, M_LONG_IDX, M_SHORT_IND, M_LONG_IND, M_SHORT_IND_IDX,
        M_LONG_IND_IDX, M_REL_DIR, M_REL_IND, M_BIT_DIR, M_BIT_IND,
        M_BIT_DIR_REL, M_BIT_IND_REL
    } mode_e;

    typedef enum logic [1:0] {
        PFX_NONE, PFX_Y_SEL, PFX_IND_SEL, PFX_YIND_SEL
    } prefix_e;

    localparam logic [7:0] Y_REGISTER_PREFIX = 8'h90;
    localparam logic [7:0] Y_INDIRECT_PREFIX = 8'h91;
    localparam logic [7:0] INDIRECT_PREFIX   = 8'h92;

    // Opcode row (upper nibble) selects the addressing family
    localparam logic [3:0] ROW_BIT_REL  = 4'h0;
    localparam logic [3:0] ROW_BIT      = 4'h1;
    localparam logic [3:0] ROW_REL      = 4'h2;
    localparam logic [3:0] ROW_RMW_DIR  = 4'h3;
    localparam logic [3:0] ROW_INH_A    = 4'h4;
    localparam logic [3:0] ROW_INH_X    = 4'h5;
    localparam logic [3:0] ROW_RMW_SIDX = 4'h6;
    localparam logic [3:0] ROW_RMW_NOFS = 4'h7;
    localparam logic [3:0] ROW_CTRL     = 4'h8;
    localparam logic [3:0] ROW_XFER     = 4'h9;
    localparam logic [3:0] ROW_IMM      = 4'hA;
    localparam logic [3:0] ROW_SDIR     = 4'hB;
    localparam logic [3:0] ROW_LDIR     = 4'hC;
    localparam logic [3:0] ROW_LIDX     = 4'hD;
    localparam logic [3:0] ROW_SIDX     = 4'hE;
    localparam logic [3:0] ROW_NOFS     = 4'hF;

    // Operations in the memory rows with no immediate form
    localparam logic [3:0] OP_STORE = 4'h7;
    localparam logic [3:0] OP_JUMP  = 4'hC;
    localparam logic [3:0] OP_CALL  = 4'hD;

    // Control row operations
    localparam logic [3:0] OP_NOP               = 4'h0;
    localparam logic [3:0] OP_TRAP              = 4'h1;
    localparam logic [3:0] OP_WAIT_FOR_INTERRUPT = 4'h2;
    localparam logic [3:0] OP_HALT              = 4'h3;
    localparam logic [3:0] OP_RAISE_MASK        = 4'h6;
    localparam logic [3:0] OP_LOWER_MASK        = 4'h7;

    localparam logic [1:0]  IMASK_RESET    = 2'h3;
    localparam logic [1:0]  IMASK_RAISED   = 2'h3;
    localparam logic [1:0]  IMASK_LOWERED  = 2'h0;
    localparam logic [15:0] PAGE_ZERO_TOP  = 16'h00FF;
    localparam logic [15:0] SHORT_IDX_TOP  = 16'h01FE;
    localparam logic [2:0]  LEN_RESET      = 3'h0;

    typedef struct packed {
        mode_e      mode;
        logic [1:0] opnd_n;
        logic [1:0] ptr_n;
        logic       use_y;
        logic       ctrl;
        logic       illegal;
        logic [3:0] op;
    } decode_s;

    typedef struct packed {
        mode_e       mode;
        logic [15:0] ea;
        logic [15:0] target;
        logic [2:0]  length;
        logic        illegal;
    } result_s;

endpackage : addr_gen_pkg
